//--- hdl/sdio_pkg.sv
// Constants shared by the servo drive digital I/O object block.
// Assumes a single 100 MHz clock domain and object-index addressing.
package sdio_pkg;

  // ==========================================================
  // Object indices and subindices
  localparam logic [15:0] IDX_INPUTS = 16'h60FD;
  localparam logic [15:0] IDX_OUTPUTS = 16'h60FE;
  localparam logic [15:0] IDX_EXT_ENC = 16'h60E4;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_FIRST = 8'h01;
  localparam logic [7:0] SUB_SECOND = 8'h02;

  // ==========================================================
  // Entry counts and values after reset
  localparam logic [31:0] OUT_ENTRY_COUNT = 32'h0000_0002;
  localparam logic [31:0] ENC_ENTRY_COUNT = 32'h0000_0001;
  localparam logic [31:0] DRIVE_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h000C_0000;
  localparam logic [31:0] ENC_RESET = 32'h0000_0000;

  // ==========================================================
  // Field positions in the input status word
  localparam int IN_NEG_OT_BIT = 0;
  localparam int IN_POS_OT_BIT = 1;
  localparam int IN_HOME_BIT = 2;
  localparam int IN_SEQ_LSB = 16;
  localparam int IN_SAFE_A_BIT = 24;
  localparam int IN_SAFE_B_BIT = 25;
  localparam int SEQ_COUNT = 7;

  // Field position of the general-purpose outputs
  localparam int OUT_LSB = 17;
  localparam int OUT_COUNT = 5;
  localparam logic [31:0] OUT_FIELD_MASK = 32'h003E_0000;

  // Pin inputs: 3 switches, 7 sequence inputs, 2 safety inputs
  localparam int PIN_COUNT = 12;

endpackage

//--- hdl/sdio_sync_if.sv
// Carries the qualified pin levels from the synchroniser to the core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface sdio_sync_if;
  logic [sdio_pkg::PIN_COUNT-1:0] level;
  modport src (output level);
  modport dst (input level);
endinterface

`default_nettype wire

//--- hdl/sdio_pin_sync.sv
// Three-stage pin synchroniser with agreement qualification.
// Assumes raw pins are asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

module sdio_pin_sync (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Raw pins
  input wire logic [sdio_pkg::PIN_COUNT-1:0] pins_i,
  // Qualified levels
  sdio_sync_if.src sync
);

  logic [sdio_pkg::PIN_COUNT-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
  logic [sdio_pkg::PIN_COUNT-1:0] s1_next, s2_next, s3_next, lvl_next;

  // ==========================================================
  // Next values: a change counts once stages two and three agree
  always_comb begin
    s1_next = s1_reg;
    s2_next = s2_reg;
    s3_next = s3_reg;
    lvl_next = lvl_reg;
    if (ce_i) begin
      s1_next = pins_i;
      s2_next = s1_reg;
      s3_next = s2_reg;
      for (int i = 0; i < sdio_pkg::PIN_COUNT; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          lvl_next[i] = s3_reg[i];
        end
      end
    end
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      lvl_reg <= '0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      lvl_reg <= lvl_next;
    end
  end

  assign sync.level = lvl_reg;

endmodule

`default_nettype wire

//--- hdl/sdio_top.sv
// Digital I/O object block of a servo drive: input word, outputs, encoder.
// Assumes one 100 MHz clock; the object port is driven by same-clock logic.
`timescale 1ns/1ps
`default_nettype none

module sdio_top (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Connector input pins (asynchronous)
  input wire logic neg_overtravel_in_i,
  input wire logic pos_overtravel_in_i,
  input wire logic home_switch_in_i,
  input wire logic [6:0] seq_input_i,
  input wire logic safety_block_in_a_i,
  input wire logic safety_block_in_b_i,
  // Drive status functions (same clock)
  input wire logic [4:0] status_fn_i,
  input wire logic [4:0] status_assign_i,
  // External encoder position (same clock)
  input wire logic [31:0] ext_enc_pos_i,
  // Object access port
  input wire logic obj_rd_i,
  input wire logic obj_wr_i,
  input wire logic [15:0] obj_index_i,
  input wire logic [7:0] obj_subindex_i,
  input wire logic [31:0] obj_wdata_i,
  output logic [31:0] obj_rdata_o,
  output logic obj_ack_o,
  output logic obj_err_o,
  // General-purpose outputs one to five
  output logic [4:0] gp_output_o
);

  sdio_sync_if sync ();

  logic [sdio_pkg::PIN_COUNT-1:0] pins;
  logic [31:0] drive_reg, drive_next;
  logic [31:0] mask_reg, mask_next;
  logic [31:0] enc_reg, enc_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;
  logic err_reg, err_next;
  logic [4:0] gpo_reg, gpo_next;
  logic [31:0] in_word;
  logic hit_in_word, hit_out_count, hit_drive, hit_mask;
  logic hit_enc_count, hit_enc_pos;

  // ==========================================================
  // Pin synchroniser
  assign pins = {safety_block_in_b_i, safety_block_in_a_i, seq_input_i,
                 home_switch_in_i, pos_overtravel_in_i, neg_overtravel_in_i};

  sdio_pin_sync u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .pins_i(pins),
    .sync(sync.src)
  );

  // ==========================================================
  // Input status word assembly, reserved bits zero
  always_comb begin
    in_word = 32'h0000_0000;
    in_word[sdio_pkg::IN_NEG_OT_BIT] = sync.level[0];
    in_word[sdio_pkg::IN_POS_OT_BIT] = sync.level[1];
    in_word[sdio_pkg::IN_HOME_BIT] = sync.level[2];
    for (int i = 0; i < sdio_pkg::SEQ_COUNT; i++) begin
      in_word[sdio_pkg::IN_SEQ_LSB + i] = sync.level[3 + i];
    end
    in_word[sdio_pkg::IN_SAFE_A_BIT] = sync.level[10];
    in_word[sdio_pkg::IN_SAFE_B_BIT] = sync.level[11];
  end

  // Output field of a word, reserved bits cleared
  function automatic logic [4:0] out_field(input logic [31:0] w);
    out_field = w[sdio_pkg::OUT_LSB +: sdio_pkg::OUT_COUNT];
  endfunction

  // ==========================================================
  // Object address decode, shared by the write and read paths
  function automatic logic obj_hit(input logic [15:0] idx,
    input logic [7:0] sub, input logic [15:0] want_idx,
    input logic [7:0] want_sub);
    obj_hit = (idx == want_idx) && (sub == want_sub);
  endfunction

  // One select per readable object; at most one is high
  always_comb begin
    hit_in_word = obj_hit(obj_index_i, obj_subindex_i,
      sdio_pkg::IDX_INPUTS, sdio_pkg::SUB_COUNT);
    hit_out_count = obj_hit(obj_index_i, obj_subindex_i,
      sdio_pkg::IDX_OUTPUTS, sdio_pkg::SUB_COUNT);
    hit_drive = obj_hit(obj_index_i, obj_subindex_i,
      sdio_pkg::IDX_OUTPUTS, sdio_pkg::SUB_FIRST);
    hit_mask = obj_hit(obj_index_i, obj_subindex_i,
      sdio_pkg::IDX_OUTPUTS, sdio_pkg::SUB_SECOND);
    hit_enc_count = obj_hit(obj_index_i, obj_subindex_i,
      sdio_pkg::IDX_EXT_ENC, sdio_pkg::SUB_COUNT);
    hit_enc_pos = obj_hit(obj_index_i, obj_subindex_i,
      sdio_pkg::IDX_EXT_ENC, sdio_pkg::SUB_FIRST);
  end

  // ==========================================================
  // Object access: one-cycle answer with ack, err on bad access
  // Write wins when both strobes are high in one cycle
  always_comb begin
    drive_next = drive_reg;
    mask_next = mask_reg;
    rdata_next = rdata_reg;
    ack_next = ack_reg; // Frozen while ce_i is low
    err_next = err_reg;
    if (ce_i) begin
      ack_next = 1'b0;
      err_next = 1'b0;
      if (obj_wr_i) begin
        ack_next = 1'b1;
        if (hit_drive) begin
          drive_next = obj_wdata_i & sdio_pkg::OUT_FIELD_MASK;
        end else if (hit_mask) begin
          mask_next = obj_wdata_i & sdio_pkg::OUT_FIELD_MASK;
        end else begin
          err_next = 1'b1; // Read-only or unmapped object
        end
      end else if (obj_rd_i) begin
        ack_next = 1'b1;
        rdata_next = 32'h0000_0000;
        if (hit_in_word) begin
          rdata_next = in_word;
        end else if (hit_out_count) begin
          rdata_next = sdio_pkg::OUT_ENTRY_COUNT;
        end else if (hit_drive) begin
          rdata_next = drive_reg;
        end else if (hit_mask) begin
          rdata_next = mask_reg;
        end else if (hit_enc_count) begin
          rdata_next = sdio_pkg::ENC_ENTRY_COUNT;
        end else if (hit_enc_pos) begin
          rdata_next = enc_reg;
        end else begin
          err_next = 1'b1; // Unmapped object reads as zero
        end
      end
    end
  end

  // Object access registers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      drive_reg <= sdio_pkg::DRIVE_RESET;
      mask_reg <= sdio_pkg::MASK_RESET;
      rdata_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      drive_reg <= drive_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
    end
  end

  // ==========================================================
  // Encoder capture: one register stage from the same-clock input
  always_comb begin
    enc_next = enc_reg;
    if (ce_i) begin
      enc_next = ext_enc_pos_i;
    end
  end

  // Encoder register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      enc_reg <= sdio_pkg::ENC_RESET;
    end else begin
      enc_reg <= enc_next;
    end
  end

  // ==========================================================
  // Output drive: mask gates the software value, status ORed on top
  // A status function shows even with its mask bit clear
  always_comb begin
    gpo_next = gpo_reg;
    if (ce_i) begin
      gpo_next = (out_field(drive_reg) & out_field(mask_reg))
                 | (status_fn_i & status_assign_i);
    end
  end

  // Output register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      gpo_reg <= 5'h00;
    end else begin
      gpo_reg <= gpo_next;
    end
  end

  // Outputs straight from flip-flops
  assign obj_rdata_o = rdata_reg;
  assign obj_ack_o = ack_reg;
  assign obj_err_o = err_reg;
  assign gp_output_o = gpo_reg;

endmodule

`default_nettype wire

//--- dv/sdio_ctl_model.sv
// Controller model: issues object reads and writes to the block.
// Assumes clk_i is the block clock and one request at a time.
`timescale 1ns/1ps
`default_nettype none
module sdio_ctl_model (
  // Clock
  input wire logic clk_i,
  // Object port, controller side
  output logic rd_o,
  output logic wr_o,
  output logic [15:0] idx_o,
  output logic [7:0] sub_o,
  output logic [31:0] wd_o,
  input wire logic [31:0] rdata_i,
  input wire logic ack_i,
  input wire logic err_i
);
  initial {rd_o, wr_o, idx_o, sub_o, wd_o} = '0;
  // One request taken at an edge, then a bounded wait for the answer
  task automatic xfer(input logic w, input logic [23:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e,
    output logic to);
    int n;
    @(posedge clk_i);
    #1 {wr_o, rd_o, idx_o, sub_o, wd_o} = {w, !w, a, d};
    @(posedge clk_i);
    #1 {wr_o, rd_o} = 2'b00;
    wd_o = ~d; // Released data shows no stale value
    to = 1'b1;
    for (n = 0; n < 4 && to; n++) begin
      if (ack_i === 1'b1) begin
        {q, e, to} = {rdata_i, err_i, 1'b0};
      end else begin
        @(posedge clk_i);
        #1;
      end
    end
  endtask
endmodule
`default_nettype wire

//--- dv/sdio_monitor.sv
// Port checker for the digital I/O object block.
// Assumes ce_i is high except for the bench's two-cycle enable-low freeze.
`timescale 1ns/1ps
`default_nettype none
module sdio_monitor (
  // Clock and control
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Pins and same-clock inputs
  input wire logic neg_overtravel_in_i,
  input wire logic pos_overtravel_in_i,
  input wire logic home_switch_in_i,
  input wire logic [6:0] seq_input_i,
  input wire logic safety_block_in_a_i,
  input wire logic safety_block_in_b_i,
  input wire logic [4:0] status_fn_i,
  input wire logic [4:0] status_assign_i,
  input wire logic [31:0] ext_enc_pos_i,
  // Object port and outputs
  input wire logic obj_rd_i,
  input wire logic obj_wr_i,
  input wire logic [15:0] obj_index_i,
  input wire logic [7:0] obj_subindex_i,
  input wire logic [31:0] obj_rdata_o,
  input wire logic obj_ack_o,
  input wire logic obj_err_o,
  input wire logic [4:0] gp_output_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ==========
  // Decoded requests and expected input word
  wire logic req = ce_i && (obj_rd_i || obj_wr_i);
  wire logic rd = ce_i && obj_rd_i && !obj_wr_i;
  wire logic [23:0] ad = {obj_index_i, obj_subindex_i};
  wire logic [31:0] pin_word = {6'h00, safety_block_in_b_i,
    safety_block_in_a_i, 1'b0, seq_input_i, 13'h0000,
    home_switch_in_i, pos_overtravel_in_i, neg_overtravel_in_i};
  sequence pins_steady;
    (ce_i && $stable(pin_word))[*6];
  endsequence
  sequence enc_read;
    resetn_i ##1 (rd && ad == 24'h60E401);
  endsequence
  a_ack_follows: assert property (req ##1 ce_i |-> obj_ack_o)
    else $error("request not answered");
  a_ack_only_req: assert property (ce_i && !req ##1 ce_i |-> !obj_ack_o)
    else $error("answer without request");
  a_err_with_ack: assert property (obj_err_o |-> obj_ack_o)
    else $error("error without answer");
  a_bad_write: assert property (ce_i && obj_wr_i &&
    !(ad inside {24'h60FE01, 24'h60FE02}) |=> obj_err_o)
    else $error("bad write not refused");
  a_input_map: assert property (
    pins_steady ##0 (rd && ad == 24'h60FD00)
    |=> obj_rdata_o == $past(pin_word)) else $error("input word wrong");
  a_encoder_read: assert property (
    enc_read |=> obj_rdata_o == $past(ext_enc_pos_i, 2))
    else $error("encoder word wrong");
  a_out_reserved: assert property (
    rd && ad inside {24'h60FE01, 24'h60FE02}
    |=> (obj_rdata_o & ~sdio_pkg::OUT_FIELD_MASK) == 32'h0)
    else $error("reserved output bits set");
  a_status_or: assert property (ce_i ##1 ce_i |->
    &(gp_output_o | ~$past(status_fn_i & status_assign_i)))
    else $error("status function not ORed");
endmodule
bind sdio_top sdio_monitor mon (.*);
`default_nettype wire

//--- dv/test_servo_drive_digital_io_objects.sv
// Testbench of the digital I/O object block, with a controller model.
// Assumes a 100 MHz clock and ce_i held high except for one two-cycle freeze check.
`timescale 1ns/1ps
`default_nettype none
`define CHK(x, y) begin checks_done++; if ((x) !== (y)) begin \
  err_total++; $display("Error at %0t: got %h want %h", $time, x, y); end end
module test_servo_drive_digital_io_objects;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [11:0] pins = 12'h000;
  logic [4:0] fn = 5'h00;
  logic [4:0] asg = 5'h00;
  logic ce = 1'b1;
  logic [31:0] enc = 32'h8000_0001;
  logic rd, wr, ack, err, e, to;
  logic [15:0] idx;
  logic [7:0] sub;
  logic [31:0] wd, rdata, q;
  logic [4:0] gp;
  int err_total = 0;
  int checks_done = 0;
  always #5 clk_i = ~clk_i;
  sdio_ctl_model ctl (.clk_i(clk_i), .rd_o(rd), .wr_o(wr), .idx_o(idx),
    .sub_o(sub), .wd_o(wd), .rdata_i(rdata), .ack_i(ack), .err_i(err));
  sdio_top uut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce),
    .neg_overtravel_in_i(pins[0]), .pos_overtravel_in_i(pins[1]),
    .home_switch_in_i(pins[2]), .seq_input_i(pins[9:3]),
    .safety_block_in_a_i(pins[10]), .safety_block_in_b_i(pins[11]),
    .status_fn_i(fn), .status_assign_i(asg), .ext_enc_pos_i(enc),
    .obj_rd_i(rd), .obj_wr_i(wr), .obj_index_i(idx),
    .obj_subindex_i(sub), .obj_wdata_i(wd), .obj_rdata_o(rdata),
    .obj_ack_o(ack), .obj_err_o(err), .gp_output_o(gp));
  // One object access; a lost answer ends the run
  task automatic acc(input logic w, input logic [23:0] a,
    input logic [31:0] d);
    ctl.xfer(w, a, d, q, e, to);
    if (to) begin
      err_total++;
      conclude();
    end
  endtask
  task automatic conclude();
    $display("Mismatches %0d, comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    acc(0, 24'h60FE02, 0); `CHK(q, 32'h000C_0000)
    acc(0, 24'h60FE01, 0); `CHK(q, 32'h0)
    acc(0, 24'h60FE00, 0); `CHK(q, 32'h2)
    acc(0, 24'h60E400, 0); `CHK(q, 32'h1)
    acc(1, 24'h60FE01, 32'hFFFF_FFFF);
    @(posedge clk_i); #1 `CHK(gp, 5'h06)
    acc(0, 24'h60FE01, 0); `CHK(q, 32'h003E_0000)
    acc(1, 24'h60FE02, 32'hFFFF_FFFF);
    for (int k = 0; k < 5; k++) begin
      acc(1, 24'h60FE01, 32'h1 << (17 + k));
      @(posedge clk_i); #1 `CHK(gp, 5'h01 << k)
    end
    fn = 5'h15;
    asg = 5'h1F;
    acc(1, 24'h60FE02, 32'h0);
    @(posedge clk_i); #1 `CHK(gp, 5'h15)
    // Enable low freezes the outputs
    ce = 1'b0;
    asg = 5'h00;
    repeat (2) @(posedge clk_i);
    #1 `CHK(gp, 5'h15)
    ce = 1'b1;
    @(posedge clk_i); #1 `CHK(gp, 5'h00)
    // Status low on an assigned output leaves the software value
    asg = 5'h10;
    fn = 5'h00;
    acc(1, 24'h60FE02, 32'hFFFF_FFFF);
    @(posedge clk_i); #1 `CHK(gp, 5'h10)
    for (int k = 0; k < 12; k++) begin
      pins = 12'h001 << k;
      repeat (8) @(posedge clk_i);
      #1 acc(0, 24'h60FD00, 0);
      `CHK(q, 32'h1 << (k < 3 ? k : k < 10 ? k + 13 : k + 14))
    end
    acc(0, 24'h60E401, 0); `CHK(q, 32'h8000_0001)
    acc(1, 24'h60FD00, 32'h1); `CHK(e, 1'b1)
    acc(1, 24'h60FE00, 32'h5); `CHK(e, 1'b1)
    acc(0, 24'h123400, 0); `CHK({e, q}, 33'h1_0000_0000)
    // Reset in mid-run restores mask and drive words
    resetn_i = 1'b0;
    repeat (6) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    acc(0, 24'h60FE02, 0); `CHK(q, 32'h000C_0000)
    acc(0, 24'h60FE01, 0); `CHK(q, 32'h0)
    conclude();
  end
endmodule
`default_nettype wire
